// ---- ctom_top.sv ----
/*
 * ctom_top: maps the four cross trigger channels onto output triggers 1 and 2.
 * channel events come from the channel interface, from enabled input triggers
 * and from software application pulses. assumes an apb master on pclk and
 * one-cycle event pulses on all event inputs.
 */
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps

// How it works
// - each output mask register holds a 4-bit channel field in bits 3..0 and bits 31..4 read as zero.
// - a 0 mask bit in the output trigger 1 register keeps that channel away from trigger line 1.
// - a 1 mask bit in the output trigger 1 register turns an event on that channel into a line 1 event.
// - a 0 mask bit in the output trigger 2 register keeps that channel away from trigger line 2.
// - a 1 mask bit in the output trigger 2 register turns an event on that channel into a line 2 event.
// - software application pulses raise channel events that pass the same output masks.
// - an active input trigger raises events on the channels its own input mask enables.
module ctom_top
    import ctom_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [CTOM_AW-1:0] paddr,
    input wire logic [CTOM_DW-1:0] pwdata,
    output logic [CTOM_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ctom_chan_t chan_evt_in,
    input wire logic [CTOM_NIN-1:0] trig_in,
    output ctom_chan_t chan_evt_out,
    output logic [CTOM_NOUT-1:0] out_trigger
);

    // ================================================================
    // state
    ctom_chan_t out_mask_reg [CTOM_NOUT];
    ctom_chan_t out_mask_next [CTOM_NOUT];
    ctom_chan_t in_mask_reg [CTOM_NIN];
    ctom_chan_t in_mask_next [CTOM_NIN];
    ctom_chan_t app_pulse_reg;
    ctom_chan_t app_pulse_next;
    logic global_en_reg;
    logic global_en_next;
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic [CTOM_DW-1:0] prdata_reg;
    logic [CTOM_DW-1:0] prdata_next;
    ctom_chan_t chan_out_reg;
    ctom_chan_t chan_out_next;
    ctom_chan_t chan_evt;
    ctom_chan_t in_evt;
    ctom_acc_s acc;
    logic addr_ok;
    logic [CTOM_DW-1:0] rd_word;
    logic [CTOM_NOUT-1:0] trig_line;

    // ================================================================
    // apb access: one wait-free access phase, pready comes from a flop
    // so it is raised during setup and seen high in the first access cycle
    always_comb begin
        acc.wr = psel & penable & pready_reg & pwrite;
        acc.rd = psel & penable & pready_reg & ~pwrite;
        acc.addr = paddr;
        acc.wdata = pwdata;
    end

    always_comb begin
        addr_ok = 1'b1;
        rd_word = '0;
        if (paddr == CTOM_OUT1_MASK_OFS) begin
            rd_word[CTOM_MASK_MSB:CTOM_MASK_LSB] = out_mask_reg[0];
        end else if (paddr == CTOM_OUT2_MASK_OFS) begin
            rd_word[CTOM_MASK_MSB:CTOM_MASK_LSB] = out_mask_reg[1];
        end else if (paddr == CTOM_APP_PULSE_OFS) begin
            rd_word = '0;
        end else if (paddr == CTOM_STATUS_OFS) begin
            rd_word[CTOM_MASK_MSB:CTOM_MASK_LSB] = chan_out_reg;
            rd_word[CTOM_STAT_OUT_LSB +: CTOM_NOUT] = trig_line;
        end else if (paddr == CTOM_GLOBAL_EN_OFS) begin
            rd_word[CTOM_GLOBAL_EN_BIT] = global_en_reg;
        end else if (paddr >= CTOM_IN_MASK_BASE && paddr <= CTOM_IN_MASK_LAST && paddr[1:0] == 2'b00) begin
            rd_word[CTOM_MASK_MSB:CTOM_MASK_LSB] = in_mask_reg[paddr[4:2]];
        end else begin
            addr_ok = 1'b0;
        end
    end

    always_comb begin
        pready_next = psel & ~penable;
        pslverr_next = psel & ~penable & ~addr_ok;
        prdata_next = prdata_reg;
        if (psel && !penable && !pwrite) begin
            prdata_next = rd_word;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
        end
    end

    // ================================================================
    // register writes; reserved bits are dropped on the way in
    always_comb begin
        for (int i = 0; i < CTOM_NOUT; i++) begin
            out_mask_next[i] = out_mask_reg[i];
        end
        for (int j = 0; j < CTOM_NIN; j++) begin
            in_mask_next[j] = in_mask_reg[j];
        end
        global_en_next = global_en_reg;
        app_pulse_next = '0;
        if (acc.wr && addr_ok) begin
            if (acc.addr == CTOM_OUT1_MASK_OFS) begin
                out_mask_next[0] = acc.wdata[CTOM_MASK_MSB:CTOM_MASK_LSB];
            end else if (acc.addr == CTOM_OUT2_MASK_OFS) begin
                out_mask_next[1] = acc.wdata[CTOM_MASK_MSB:CTOM_MASK_LSB];
            end else if (acc.addr == CTOM_APP_PULSE_OFS) begin
                app_pulse_next = acc.wdata[CTOM_MASK_MSB:CTOM_MASK_LSB];
            end else if (acc.addr == CTOM_GLOBAL_EN_OFS) begin
                global_en_next = acc.wdata[CTOM_GLOBAL_EN_BIT];
            end else if (acc.addr >= CTOM_IN_MASK_BASE) begin
                in_mask_next[acc.addr[4:2]] = acc.wdata[CTOM_MASK_MSB:CTOM_MASK_LSB];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < CTOM_NOUT; i++) begin
                out_mask_reg[i] <= CTOM_MASK_RST;
            end
            for (int j = 0; j < CTOM_NIN; j++) begin
                in_mask_reg[j] <= CTOM_MASK_RST;
            end
            global_en_reg <= CTOM_GLOBAL_EN_RST;
            app_pulse_reg <= CTOM_MASK_RST;
        end else begin
            for (int i = 0; i < CTOM_NOUT; i++) begin
                out_mask_reg[i] <= out_mask_next[i];
            end
            for (int j = 0; j < CTOM_NIN; j++) begin
                in_mask_reg[j] <= in_mask_next[j];
            end
            global_en_reg <= global_en_next;
            app_pulse_reg <= app_pulse_next;
        end
    end

    // ================================================================
    // channel events: channel interface, inputs and application pulses
    always_comb begin
        in_evt = '0;
        for (int j = 0; j < CTOM_NIN; j++) begin
            in_evt = in_evt | ({CTOM_NCHAN{trig_in[j]}} & in_mask_reg[j]);
        end
        // the global enable gates every source, so software can quiet the matrix
        chan_evt = global_en_reg ? (chan_evt_in | in_evt | app_pulse_reg) : '0;
        chan_out_next = global_en_reg ? (in_evt | app_pulse_reg) : '0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_out_reg <= CTOM_MASK_RST;
        end else begin
            chan_out_reg <= chan_out_next;
        end
    end

    // ================================================================
    // output trigger lines
    for (genvar k = 0; k < CTOM_NOUT; k++) begin : g_out
        ctom_out_map u_map (
            .pclk(pclk),
            .presetn(presetn),
            .chan_evt(chan_evt),
            .chan_mask(out_mask_reg[k]),
            .trig_reg(trig_line[k])
        );
    end

    assign out_trigger = trig_line;
    assign chan_evt_out = chan_out_reg;
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

    // ================================================================
    // checks
    mask_rsvd_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (acc.rd && !pslverr_reg && (paddr == CTOM_OUT1_MASK_OFS || paddr == CTOM_OUT2_MASK_OFS))
        |-> prdata_reg[31:4] == 28'h000_0000)
        else $error("reserved mask bits read nonzero");

    mask_write_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (acc.wr && paddr == CTOM_OUT1_MASK_OFS) |=> out_mask_reg[0] == $past(pwdata[3:0]))
        else $error("trigger 1 mask not updated by write");

    out1_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
        ((chan_evt & out_mask_reg[0]) == 4'h0) |=> !out_trigger[0])
        else $error("trigger 1 fired from a masked channel");

    out1_fires_a: assert property (@(posedge pclk) disable iff (!presetn)
        ((chan_evt & out_mask_reg[0]) != 4'h0) |=> out_trigger[0])
        else $error("trigger 1 missed an enabled channel event");

    out2_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
        ((chan_evt & out_mask_reg[1]) == 4'h0) |=> !out_trigger[1])
        else $error("trigger 2 fired from a masked channel");

    out2_fires_a: assert property (@(posedge pclk) disable iff (!presetn)
        ((chan_evt & out_mask_reg[1]) != 4'h0) |=> out_trigger[1])
        else $error("trigger 2 missed an enabled channel event");

    app_pulse_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        (acc.wr && paddr == CTOM_APP_PULSE_OFS && global_en_reg && (pwdata[3:0] & out_mask_reg[0]) != 4'h0
         && !(psel && !penable && paddr == CTOM_GLOBAL_EN_OFS)) |=> ##1 out_trigger[0])
        else $error("application pulse did not reach trigger 1");

    input_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        (global_en_reg && trig_in[0] && (in_mask_reg[0] & out_mask_reg[1]) != 4'h0) |=> out_trigger[1])
        else $error("enabled input trigger did not reach trigger 2");

endmodule

// ---- ctom_pkg.sv ----
/*
 * ctom_pkg: constants and carrier types for the cross trigger output mapping.
 * assumes a 32-bit apb slave port with word-aligned registers.
 */
package ctom_pkg;

    // ================================================================
    // sizes
    localparam int CTOM_NCHAN = 4;
    localparam int CTOM_NIN = 8;
    localparam int CTOM_NOUT = 2;
    localparam int CTOM_AW = 12;
    localparam int CTOM_DW = 32;

    // ================================================================
    // register byte offsets
    localparam logic [11:0] CTOM_OUT1_MASK_OFS = 12'h000;
    localparam logic [11:0] CTOM_OUT2_MASK_OFS = 12'h004;
    localparam logic [11:0] CTOM_APP_PULSE_OFS = 12'h008;
    localparam logic [11:0] CTOM_STATUS_OFS = 12'h00C;
    localparam logic [11:0] CTOM_GLOBAL_EN_OFS = 12'h010;
    localparam logic [11:0] CTOM_IN_MASK_BASE = 12'h020;
    localparam logic [11:0] CTOM_IN_MASK_LAST = 12'h03C;

    // ================================================================
    // field positions and reset values
    localparam int CTOM_MASK_LSB = 0;
    localparam int CTOM_MASK_MSB = 3;
    localparam int CTOM_STAT_OUT_LSB = 4;
    localparam int CTOM_GLOBAL_EN_BIT = 0;
    localparam logic [3:0] CTOM_MASK_RST = 4'h0;
    localparam logic CTOM_GLOBAL_EN_RST = 1'b1;

    typedef logic [CTOM_NCHAN-1:0] ctom_chan_t;

    // one decoded register access, taken in the access phase
    typedef struct packed {
        logic wr;
        logic rd;
        logic [CTOM_AW-1:0] addr;
        logic [CTOM_DW-1:0] wdata;
    } ctom_acc_s;

endpackage

// ---- ctom_out_map.sv ----
/*
 * ctom_out_map: one output trigger line, built from the channel events and
 * the line's channel mask. assumes events are one-cycle pulses on pclk.
 */
`timescale 1ns/1ps
module ctom_out_map
    import ctom_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire ctom_chan_t chan_evt,
    input wire ctom_chan_t chan_mask,
    output logic trig_reg
);

    logic trig_next;

    // ================================================================
    // and-or mapping, registered so the pin comes from a flop
    always_comb begin
        trig_next = |(chan_evt & chan_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_reg <= 1'b0;
        end else begin
            trig_reg <= trig_next;
        end
    end

    // ================================================================
    // checks
    map_or_and_a: assert property (@(posedge pclk) disable iff (!presetn)
        trig_reg == |($past(chan_evt) & $past(chan_mask)))
        else $error("output line differs from masked channel or");

endmodule

// ---- ctom_peer.sv ----
/*
 * ctom_peer: trigger-line receiver standing in for the cores and debug parts.
 * assumes out_trigger events are one-cycle pulses on pclk; counts them per line.
 */
`timescale 1ns/1ps
module ctom_peer
    import ctom_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [CTOM_NOUT-1:0] out_trigger,
    output logic [15:0] hits1,
    output logic [15:0] hits2
);
    // ================================================================
    // event counters
    // a level held too long shows up as extra counts, not as one event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hits1 <= 16'h0000;
            hits2 <= 16'h0000;
        end else begin
            hits1 <= hits1 + 16'(out_trigger[0]);
            hits2 <= hits2 + 16'(out_trigger[1]);
        end
    end
endmodule

// ---- ctom_top_bench.sv ----
/*
 * ctom_top_bench: self-checking bench for the output trigger mapping.
 * assumes the zero-wait apb slave and one-cycle event latency of ctom_top.
 */
`timescale 1ns/1ps
module ctom_top_bench
    import ctom_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic [CTOM_AW-1:0] paddr = '0;
    logic [CTOM_DW-1:0] pwdata = '0, prdata, rd;
    ctom_chan_t chan_evt_in = '0, chan_evt_out;
    logic [CTOM_NIN-1:0] trig_in = '0;
    logic [CTOM_NOUT-1:0] out_trigger;
    logic [15:0] hits1, hits2, e1 = '0, e2 = '0;
    logic [3:0] m1 = 4'h5, m2 = 4'hA;
    int n_fail = 0, n_checks = 0, cyc = 0;

    ctom_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chan_evt_in(chan_evt_in), .trig_in(trig_in),
        .chan_evt_out(chan_evt_out), .out_trigger(out_trigger));
    ctom_peer i_peer (.pclk(pclk), .presetn(presetn), .out_trigger(out_trigger),
        .hits1(hits1), .hits2(hits2));

    initial begin
        forever #12.5 pclk = ~pclk;
    end

    // ================================================================
    // tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        if (n_fail == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // idle edge first, so psel is never assigned twice in one step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic evt(input ctom_chan_t c, input logic [7:0] t, input logic [1:0] o, input ctom_chan_t ce);
        @(posedge pclk);
        chan_evt_in <= c;
        trig_in <= t;
        @(posedge pclk);
        chan_evt_in <= '0;
        trig_in <= '0;
        #1;
        chk("out_trigger", 32'(o), 32'(out_trigger));
        chk("chan_evt_out", 32'(ce), 32'(chan_evt_out));
        e1 += 16'(o[0]);
        e2 += 16'(o[1]);
    endtask

    // ================================================================
    // tests
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, CTOM_OUT1_MASK_OFS, 0);
        chk("mask1 reset", 32'(CTOM_MASK_RST), rd);
        apb(0, CTOM_OUT2_MASK_OFS, 0);
        chk("mask2 reset", 32'(CTOM_MASK_RST), rd);
        apb(0, CTOM_GLOBAL_EN_OFS, 0);
        chk("global en reset", 32'(CTOM_GLOBAL_EN_RST), rd);
        apb(1, CTOM_OUT1_MASK_OFS, 32'hFFFF_FFF5);
        apb(0, CTOM_OUT1_MASK_OFS, 0);
        chk("mask1", 32'h0000_0005, rd);
        apb(1, CTOM_OUT2_MASK_OFS, 32'h0000_000A);
        apb(0, CTOM_OUT2_MASK_OFS, 0);
        chk("mask2", 32'h0000_000A, rd);
        for (int c = 0; c < CTOM_NCHAN; c++) begin
            evt(ctom_chan_t'(1 << c), 0, {m2[c], m1[c]}, 0);
        end
        evt(4'hF, 0, 2'b11, 0);
        apb(1, CTOM_APP_PULSE_OFS, 32'h0000_0004);
        @(posedge pclk);
        #1;
        chk("app out_trigger", 32'h0000_0001, 32'(out_trigger));
        chk("app chan_evt_out", 32'h0000_0004, 32'(chan_evt_out));
        e1 += 16'h0001;
        apb(1, CTOM_IN_MASK_LAST, 32'h0000_0008);
        apb(0, CTOM_IN_MASK_LAST, 0);
        chk("in mask 7", 32'h0000_0008, rd);
        evt(0, 8'h80, 2'b10, 4'h8);
        evt(0, 8'h01, 2'b00, 4'h0);
        // input 0 onto channels 0 and 1 reaches both lines through their masks
        apb(1, CTOM_IN_MASK_BASE, 32'h0000_0003);
        evt(0, 8'h01, 2'b11, 4'h3);
        apb(1, CTOM_GLOBAL_EN_OFS, 0);
        evt(4'hF, 8'h80, 2'b00, 4'h0);
        apb(1, CTOM_GLOBAL_EN_OFS, 1);
        apb(0, 12'h100, 0);
        chk("unmapped err", 1, 32'(err));
        chk("unmapped data", 0, rd);
        repeat (2) @(posedge pclk);
        chk("line1 events", 32'(e1), 32'(hits1));
        chk("line2 events", 32'(e2), 32'(hits2));
        // second reset in mid-run: masks and input masks must come back cleared
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, CTOM_OUT2_MASK_OFS, 0);
        chk("mask2 after reset", 32'(CTOM_MASK_RST), rd);
        evt(4'h1, 8'h01, 2'b00, 4'h0);
        close_out();
    end

    // the whole run takes under a hundred cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            close_out();
        end
    end
endmodule
